/* File: src/xpt_pkg.sv */
// constants shared by the crosspoint setup sequencer and its helpers
// assumes one 20 MHz clock and synchronous command inputs
// Operation
// - after reset every relay is open, the relays are the display source, the applied index is 000 and the selected store index is 001.
// - each row keeps a make-before-break, break-before-make or don't care policy that shapes every relay change.
// - toggling a policy on a row flips it, and setting one policy on a row clears the other.
// - store locations 1 to 100 can be selected, and selecting the store view with no number shows setup 1.
// - leading zeros count toward the three-digit limit but otherwise do not change the location.
// - an open or close on a crosspoint A1 to H72 changes that display bit and sets the edited flag.
// - a save with no number writes the display into the selected store location.
// - a save with a valid number writes the display there and makes it the selected store index.
// - an apply drives the relays to match the display.
// - an apply while the store view is displayed copies the selected store index into the applied index.
// - a manual trigger with keypress source and trigger enabled copies setup 1 to the relays and sets the applied index to 001.
package xpt_pkg;
    localparam int ROWS        = 8;
    localparam int COLS        = 72;
    localparam int SETUP_BITS  = ROWS * COLS;
    localparam int STORE_DEPTH = 100;
    localparam int IDX_W       = 7;
    localparam int ENTRY_W     = 10;
    localparam int MAX_DIGITS  = 3;

    localparam logic [IDX_W-1:0] APPLIED_IDX_RST = 7'h00;
    localparam logic [IDX_W-1:0] STORE_IDX_RST   = 7'h01;
    localparam logic [IDX_W-1:0] TRIG_IDX        = 7'h01;
    localparam logic [IDX_W-1:0] STORE_IDX_MAX   = 7'h64;
    localparam logic [6:0]       COL_MAX         = 7'h47;
    localparam logic [3:0]       DIGIT_MAX       = 4'h9;

    // command codes on cmd_code
    localparam logic [3:0] CMD_OPEN       = 4'h0;
    localparam logic [3:0] CMD_CLOSE      = 4'h1;
    localparam logic [3:0] CMD_TOGGLE_MB  = 4'h2;
    localparam logic [3:0] CMD_TOGGLE_BM  = 4'h3;
    localparam logic [3:0] CMD_SEL_RELAYS = 4'h4;
    localparam logic [3:0] CMD_SEL_STORE  = 4'h5;
    localparam logic [3:0] CMD_SAVE       = 4'h6;
    localparam logic [3:0] CMD_APPLY      = 4'h7;
endpackage

/* File: src/entry_parser.sv */
// decimal number entry for store locations
// assumes digit and clear strobes are single-cycle and synchronous
`timescale 1ns/1ps
`default_nettype none
module entry_parser
    import xpt_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               digit_valid,
    input  wire logic [3:0]         digit,
    input  wire logic               clear,
    output logic     [ENTRY_W-1:0]  value_q,
    output logic                    present_q
);
    logic [ENTRY_W-1:0] value_d;
    logic               present_d;
    logic [1:0]         count_q;
    logic [1:0]         count_d;

    // leading zeros add nothing to the value, so 007 equals 7
    always_comb begin
        value_d   = value_q;
        present_d = present_q;
        count_d   = count_q;
        if (clear) begin
            value_d   = '0;
            present_d = 1'b0;
            count_d   = '0;
        end else if (digit_valid && digit <= DIGIT_MAX && count_q < 2'(MAX_DIGITS)) begin
            value_d   = ENTRY_W'(value_q * 10 + digit);
            present_d = 1'b1;
            count_d   = count_q + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value_q   <= '0;
            present_q <= 1'b0;
            count_q   <= '0;
        end else begin
            value_q   <= value_d;
            present_q <= present_d;
            count_q   <= count_d;
        end
    end
endmodule
`default_nettype wire

/* File: src/relay_driver.sv */
// two-phase relay update honouring the per-row switching policy
// assumes start is a single-cycle pulse taken only while busy_q is low
`timescale 1ns/1ps
`default_nettype none
module relay_driver
    import xpt_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  start,
    input  wire logic [SETUP_BITS-1:0] target,
    input  wire logic [ROWS-1:0]       mb_rows,
    input  wire logic [ROWS-1:0]       bm_rows,
    output logic     [SETUP_BITS-1:0]  relays_q,
    output logic                       busy_q
);
    logic [SETUP_BITS-1:0] relays_d;
    logic [SETUP_BITS-1:0] first_step;
    logic [SETUP_BITS-1:0] target_q;
    logic [SETUP_BITS-1:0] target_d;
    logic                  busy_d;

    // first step per row: mb closes new points only, bm opens old points only
    genvar r;
    generate
        for (r = 0; r < ROWS; r++) begin : g_row
            always_comb begin
                if (mb_rows[r])
                    first_step[r*COLS +: COLS] = relays_q[r*COLS +: COLS] | target[r*COLS +: COLS];
                else if (bm_rows[r])
                    first_step[r*COLS +: COLS] = relays_q[r*COLS +: COLS] & target[r*COLS +: COLS];
                else
                    first_step[r*COLS +: COLS] = target[r*COLS +: COLS];
            end
        end
    endgenerate

    // second step always lands on the full target
    always_comb begin
        relays_d = relays_q;
        target_d = target_q;
        busy_d   = 1'b0;
        if (busy_q) begin
            relays_d = target_q;
        end else if (start) begin
            relays_d = first_step;
            target_d = target;
            busy_d   = 1'b1;
        end
    end

    // all relays open out of reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            relays_q <= '0;
            target_q <= '0;
            busy_q   <= 1'b0;
        end else begin
            relays_q <= relays_d;
            target_q <= target_d;
            busy_q   <= busy_d;
        end
    end
endmodule
`default_nettype wire

/* File: src/switch_setup_sequencer.sv */
// setup sequencer: display, 100-entry store and live relays of an 8 x 72 matrix
// assumes command, digit and trigger strobes are single-cycle and synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module switch_setup_sequencer
    import xpt_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  cmd_valid,
    input  wire logic [3:0]            cmd_code,
    input  wire logic [2:0]            cmd_row,
    input  wire logic [6:0]            cmd_col,
    input  wire logic                  digit_valid,
    input  wire logic [3:0]            digit,
    input  wire logic                  entry_clear,
    input  wire logic                  keypress_trigger_source,
    input  wire logic                  trigger_enable,
    input  wire logic                  manual_trigger,
    output logic     [SETUP_BITS-1:0]  relays_q,
    output logic     [SETUP_BITS-1:0]  view_q,
    output logic                       src_store_q,
    output logic                       display_edited_q,
    output logic     [IDX_W-1:0]       applied_idx_q,
    output logic     [IDX_W-1:0]       store_idx_q,
    output logic     [ROWS-1:0]        mb_rows_q,
    output logic     [ROWS-1:0]        bm_rows_q,
    output logic                       entry_error_q,
    output logic                       busy_q
);
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_APPLY = 2'b10
    } state_e;

    state_e                state_q;
    state_e                state_d;
    logic [SETUP_BITS-1:0] view_d;
    logic                  src_store_d;
    logic                  display_edited_d;
    logic [IDX_W-1:0]      applied_idx_d;
    logic [IDX_W-1:0]      store_idx_d;
    logic [ROWS-1:0]       mb_rows_d;
    logic [ROWS-1:0]       bm_rows_d;
    logic                  entry_error_d;

    logic [SETUP_BITS-1:0] store_q [STORE_DEPTH];
    logic                  store_we;
    logic [IDX_W-1:0]      store_widx;
    logic [IDX_W-1:0]      read_idx;
    logic [SETUP_BITS-1:0] read_data;

    logic [ENTRY_W-1:0]    entry_value;
    logic                  entry_present;
    logic                  entry_take;
    logic                  entry_ok;
    logic [IDX_W-1:0]      entry_idx;

    logic                  drv_start;
    logic [SETUP_BITS-1:0] drv_target;
    logic                  drv_busy;
    logic                  trig_fire;
    logic [9:0]            bit_pos;
    logic                  col_ok;

    entry_parser u_entry (
        .clk         (clk),
        .rst_n       (rst_n),
        .digit_valid (digit_valid),
        .digit       (digit),
        .clear       (entry_clear | entry_take),
        .value_q     (entry_value),
        .present_q   (entry_present)
    );

    relay_driver u_driver (
        .clk      (clk),
        .rst_n    (rst_n),
        .start    (drv_start),
        .target   (drv_target),
        .mb_rows  (mb_rows_q),
        .bm_rows  (bm_rows_q),
        .relays_q (relays_q),
        .busy_q   (drv_busy)
    );

    // entry decode: a location is valid only within 1..100
    always_comb begin
        entry_ok  = entry_present && entry_value != '0
                    && entry_value <= ENTRY_W'(STORE_IDX_MAX);
        entry_idx = IDX_W'(entry_value);
    end

    // crosspoint bit position, row major
    always_comb begin
        col_ok  = cmd_col <= COL_MAX;
        bit_pos = 10'(cmd_row * COLS + cmd_col);
    end

    // store read port; location n lives at entry n-1
    always_comb begin
        read_data = store_q[read_idx - 7'h01];
    end

    // manual trigger only with keypress source and triggering enabled
    always_comb begin
        trig_fire = manual_trigger && keypress_trigger_source && trigger_enable;
    end

    // command decode; commands arriving while a relay update runs are dropped
    always_comb begin
        state_d          = state_q;
        view_d           = view_q;
        src_store_d      = src_store_q;
        display_edited_d = display_edited_q;
        applied_idx_d    = applied_idx_q;
        store_idx_d      = store_idx_q;
        mb_rows_d        = mb_rows_q;
        bm_rows_d        = bm_rows_q;
        entry_error_d    = entry_error_q;
        store_we         = 1'b0;
        store_widx       = store_idx_q;
        read_idx         = TRIG_IDX;
        entry_take       = 1'b0;
        drv_start        = 1'b0;
        drv_target       = view_q;
        unique case (state_q)
            ST_IDLE: begin
                if (trig_fire) begin
                    // trigger wins over a same-cycle command
                    read_idx      = TRIG_IDX;
                    drv_target    = read_data;
                    drv_start     = 1'b1;
                    applied_idx_d = TRIG_IDX;
                    if (!src_store_q && !display_edited_q)
                        view_d = read_data;
                    state_d = ST_APPLY;
                end else if (cmd_valid) begin
                    unique case (cmd_code)
                        CMD_OPEN, CMD_CLOSE: begin
                            if (col_ok) begin
                                view_d[bit_pos]  = (cmd_code == CMD_CLOSE);
                                display_edited_d = 1'b1;
                            end
                        end
                        CMD_TOGGLE_MB: begin
                            mb_rows_d[cmd_row] = ~mb_rows_q[cmd_row];
                            if (!mb_rows_q[cmd_row])
                                bm_rows_d[cmd_row] = 1'b0;
                        end
                        CMD_TOGGLE_BM: begin
                            bm_rows_d[cmd_row] = ~bm_rows_q[cmd_row];
                            if (!bm_rows_q[cmd_row])
                                mb_rows_d[cmd_row] = 1'b0;
                        end
                        CMD_SEL_RELAYS: begin
                            view_d           = relays_q;
                            src_store_d      = 1'b0;
                            display_edited_d = 1'b0;
                        end
                        CMD_SEL_STORE: begin
                            entry_take = 1'b1;
                            if (!entry_present || entry_ok) begin
                                // no number means setup 1
                                read_idx         = entry_present ? entry_idx : TRIG_IDX;
                                view_d           = read_data;
                                store_idx_d      = read_idx;
                                src_store_d      = 1'b1;
                                display_edited_d = 1'b0;
                                entry_error_d    = 1'b0;
                            end else begin
                                entry_error_d = 1'b1;
                            end
                        end
                        CMD_SAVE: begin
                            entry_take = 1'b1;
                            if (!entry_present) begin
                                store_we   = 1'b1;
                                store_widx = store_idx_q;
                            end else if (entry_ok) begin
                                store_we    = 1'b1;
                                store_widx  = entry_idx;
                                store_idx_d = entry_idx;
                                entry_error_d = 1'b0;
                            end else begin
                                entry_error_d = 1'b1;
                            end
                        end
                        CMD_APPLY: begin
                            drv_target = view_q;
                            drv_start  = 1'b1;
                            if (src_store_q)
                                applied_idx_d = store_idx_q;
                            state_d = ST_APPLY;
                        end
                        default: begin
                            // unused codes are ignored
                        end
                    endcase
                end
            end
            ST_APPLY: begin
                // wait out the two relay steps
                if (!drv_busy && !drv_start)
                    state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // control registers, reset to the power-up view of the relays
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q          <= ST_IDLE;
            view_q           <= '0;
            src_store_q      <= 1'b0;
            display_edited_q <= 1'b0;
            applied_idx_q    <= APPLIED_IDX_RST;
            store_idx_q      <= STORE_IDX_RST;
            mb_rows_q        <= '0;
            bm_rows_q        <= '0;
            entry_error_q    <= 1'b0;
            busy_q           <= 1'b0;
        end else begin
            state_q          <= state_d;
            view_q           <= view_d;
            src_store_q      <= src_store_d;
            display_edited_q <= display_edited_d;
            applied_idx_q    <= applied_idx_d;
            store_idx_q      <= store_idx_d;
            mb_rows_q        <= mb_rows_d;
            bm_rows_q        <= bm_rows_d;
            entry_error_q    <= entry_error_d;
            busy_q           <= (state_d == ST_APPLY);
        end
    end

    // setup store, one write port; cleared at reset as blank setups
    genvar i;
    generate
        for (i = 0; i < STORE_DEPTH; i++) begin : g_store
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n)
                    store_q[i] <= '0;
                else if (store_we && store_widx == IDX_W'(i + 1))
                    store_q[i] <= view_q;
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* File: bench/switch_setup_sequencer_asserts.sv */
// port-level checker for the setup sequencer
// assumes the single clk domain and the async active-low rst_n
`timescale 1ns/1ps
`default_nettype none
module switch_setup_sequencer_asserts
    import xpt_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  cmd_valid,
    input wire logic [3:0]            cmd_code,
    input wire logic [2:0]            cmd_row,
    input wire logic [6:0]            cmd_col,
    input wire logic                  keypress_trigger_source,
    input wire logic                  trigger_enable,
    input wire logic                  manual_trigger,
    input wire logic [SETUP_BITS-1:0] relays_q,
    input wire logic [SETUP_BITS-1:0] view_q,
    input wire logic                  src_store_q,
    input wire logic                  display_edited_q,
    input wire logic [IDX_W-1:0]      applied_idx_q,
    input wire logic [IDX_W-1:0]      store_idx_q,
    input wire logic [ROWS-1:0]       mb_rows_q,
    input wire logic [ROWS-1:0]       bm_rows_q,
    input wire logic                  busy_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic                  fire;
    logic                  take;
    logic                  cur_mb;
    logic [SETUP_BITS-1:0] mbm;
    logic [SETUP_BITS-1:0] bmm;
    logic [SETUP_BITS-1:0] step1;
    // a firing trigger steals the cycle, so the command is not taken
    assign fire = manual_trigger && keypress_trigger_source && trigger_enable;
    assign take = cmd_valid && !busy_q && !fire;
    assign cur_mb = mb_rows_q[cmd_row];
    // first relay step expected from the row policies
    always_comb begin
        for (int r = 0; r < ROWS; r++) begin
            mbm[r*COLS +: COLS] = {COLS{mb_rows_q[r]}};
            bmm[r*COLS +: COLS] = {COLS{bm_rows_q[r]}};
        end
        step1 = (mbm & (relays_q | view_q)) | (bmm & relays_q & view_q)
            | (~mbm & ~bmm & view_q);
    end
    property p_reset;
        !$past(rst_n) |-> relays_q == '0 && !src_store_q
            && applied_idx_q == APPLIED_IDX_RST && store_idx_q == STORE_IDX_RST;
    endproperty
    a_reset: assert property (p_reset) else $error("state after reset wrong");
    property p_close;
        take && cmd_code == CMD_CLOSE && cmd_col <= COL_MAX
            |=> view_q[$past(cmd_row)*COLS + $past(cmd_col)] && display_edited_q;
    endproperty
    a_close: assert property (p_close) else $error("close did not set view bit");
    property p_busy;
        take && cmd_code == CMD_APPLY |=> busy_q[*2] ##1 !busy_q;
    endproperty
    a_busy: assert property (p_busy) else $error("apply busy length wrong");
    property p_step;
        take && cmd_code == CMD_APPLY |=> relays_q == $past(step1);
    endproperty
    a_step: assert property (p_step) else $error("first relay step ignores policy");
    property p_final;
        take && cmd_code == CMD_APPLY |-> ##2 relays_q == $past(view_q, 2);
    endproperty
    a_final: assert property (p_final) else $error("relays differ from view");
    property p_idx;
        take && cmd_code == CMD_APPLY && src_store_q |=> applied_idx_q == $past(store_idx_q);
    endproperty
    a_idx: assert property (p_idx) else $error("applied index not store index");
    property p_trig;
        fire && !busy_q |=> applied_idx_q == TRIG_IDX && busy_q;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger did not apply setup 1");
    property p_toggle;
        take && cmd_code == CMD_TOGGLE_MB |=> mb_rows_q[$past(cmd_row)] != $past(cur_mb)
            && !(mb_rows_q & bm_rows_q);
    endproperty
    a_toggle: assert property (p_toggle) else $error("policy toggle wrong");
endmodule
bind switch_setup_sequencer switch_setup_sequencer_asserts u_asserts (
    .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_row(cmd_row), .cmd_col(cmd_col), .keypress_trigger_source(keypress_trigger_source),
    .trigger_enable(trigger_enable), .manual_trigger(manual_trigger), .relays_q(relays_q),
    .view_q(view_q), .src_store_q(src_store_q), .display_edited_q(display_edited_q),
    .applied_idx_q(applied_idx_q), .store_idx_q(store_idx_q), .mb_rows_q(mb_rows_q),
    .bm_rows_q(bm_rows_q), .busy_q(busy_q));
`default_nettype wire

/* File: bench/panel_model.sv */
// front-panel operator model driving the sequencer's key inputs
// assumes the bench calls its tasks; every change lands on a falling edge
`timescale 1ns/1ps
`default_nettype none
module panel_model (
    input  wire logic  clk,
    output logic       cmd_valid,
    output logic [3:0] cmd_code,
    output logic [2:0] cmd_row,
    output logic [6:0] cmd_col,
    output logic       digit_valid,
    output logic [3:0] digit,
    output logic       entry_clear,
    output logic       ksrc,
    output logic       trig_en,
    output logic       mtrig
);
    // idle keypad at time zero
    initial begin
        {cmd_valid, digit_valid, entry_clear, ksrc, trig_en, mtrig} = 6'h00;
        {cmd_code, cmd_row, cmd_col, digit} = 18'h00000;
    end
    // one strobe; fields scrambled afterwards so stale values never match
    task automatic press(input logic [3:0] c, input logic [2:0] r, input logic [6:0] k);
        @(negedge clk);
        {cmd_valid, cmd_code, cmd_row, cmd_col} = {1'b1, c, r, k};
        @(negedge clk);
        {cmd_valid, cmd_code, cmd_row, cmd_col} = {1'b0, ~c, ~r, ~k};
    endtask
    task automatic key(input logic [3:0] d);
        @(negedge clk);
        {digit_valid, digit} = {1'b1, d};
        @(negedge clk);
        {digit_valid, digit} = {1'b0, ~d};
    endtask
    task automatic clr();
        @(negedge clk);
        entry_clear = 1'b1;
        @(negedge clk);
        entry_clear = 1'b0;
    endtask
    // source and enable are chosen before any manual trigger
    task automatic arm(input logic s, input logic e);
        @(negedge clk);
        {ksrc, trig_en} = {s, e};
    endtask
    task automatic trig();
        @(negedge clk);
        mtrig = 1'b1;
        @(negedge clk);
        mtrig = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: bench/switch_setup_sequencer_tb_top.sv */
// self-checking bench for the setup sequencer
// assumes panel_model supplies all keypad inputs; 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
module switch_setup_sequencer_tb_top
    import xpt_pkg::*;
;
    logic                  clk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  cmd_valid, digit_valid, entry_clear, ksrc, trig_en, mtrig;
    logic [3:0]            cmd_code, digit;
    logic [2:0]            cmd_row;
    logic [6:0]            cmd_col, applied_idx_q, store_idx_q;
    logic [SETUP_BITS-1:0] relays_q, view_q, v1, v2;
    logic [ROWS-1:0]       mb_rows_q, bm_rows_q;
    logic                  src_store_q, display_edited_q, entry_error_q, busy_q;
    int                    n_fail = 0;
    int                    n_checks = 0;
    always #25 clk = ~clk;
    panel_model pm (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_row(cmd_row),
        .cmd_col(cmd_col), .digit_valid(digit_valid), .digit(digit),
        .entry_clear(entry_clear), .ksrc(ksrc), .trig_en(trig_en), .mtrig(mtrig));
    switch_setup_sequencer dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_row(cmd_row), .cmd_col(cmd_col), .digit_valid(digit_valid),
        .digit(digit), .entry_clear(entry_clear), .keypress_trigger_source(ksrc),
        .trigger_enable(trig_en), .manual_trigger(mtrig), .relays_q(relays_q),
        .view_q(view_q), .src_store_q(src_store_q), .display_edited_q(display_edited_q),
        .applied_idx_q(applied_idx_q), .store_idx_q(store_idx_q), .mb_rows_q(mb_rows_q),
        .bm_rows_q(bm_rows_q), .entry_error_q(entry_error_q), .busy_q(busy_q));
    task automatic conclude();
        if (n_fail == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [SETUP_BITS-1:0] e,
                       input logic [SETUP_BITS-1:0] g);
        n_checks++;
        if (g !== e) begin
            $display("Error %s expected %0h seen %0h", nm, e, g);
            n_fail++;
        end
    endtask
    // bounded wait for the relay update to finish
    task automatic idle();
        int n;
        n = 0;
        while (busy_q !== 1'b0 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (busy_q !== 1'b0) begin
            n_fail++;
            conclude();
        end
    endtask
    // main sequence; expectations built from A1 and H72 bit positions
    initial begin
        v1 = '0;
        v1[0] = 1'b1;
        v1[575] = 1'b1;
        v2 = v1;
        v2[0] = 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        chk("relays", '0, relays_q);
        chk("src", 1'b0, src_store_q);
        chk("applied", 7'h00, applied_idx_q);
        chk("store_idx", 7'h01, store_idx_q);
        pm.press(CMD_CLOSE, 3'h0, 7'h00);
        pm.press(CMD_CLOSE, 3'h7, 7'h47);
        pm.press(CMD_CLOSE, 3'h0, 7'h48);
        chk("view", v1, view_q);
        chk("edited", 1'b1, display_edited_q);
        pm.press(CMD_SAVE, 3'h3, 7'h11);
        chk("store_idx", 7'h01, store_idx_q);
        pm.press(CMD_OPEN, 3'h0, 7'h00);
        chk("view", v2, view_q);
        pm.key(4'h0);
        pm.key(4'h5);
        pm.press(CMD_SAVE, 3'h6, 7'h47);
        chk("store_idx", 7'h05, store_idx_q);
        pm.key(4'h1);
        pm.key(4'h0);
        pm.key(4'h1);
        pm.press(CMD_SAVE, 3'h1, 7'h7F);
        chk("error", 1'b1, entry_error_q);
        chk("store_idx", 7'h05, store_idx_q);
        pm.key(4'h9);
        pm.clr();
        pm.press(CMD_SAVE, 3'h4, 7'h05);
        chk("store_idx", 7'h05, store_idx_q);
        pm.key(4'h1);
        pm.key(4'h0);
        pm.key(4'h0);
        pm.press(CMD_SAVE, 3'h2, 7'h30);
        chk("store_idx", 7'h64, store_idx_q);
        chk("error", 1'b0, entry_error_q);
        pm.key(4'h0);
        pm.key(4'h0);
        pm.key(4'h5);
        pm.press(CMD_SEL_STORE, 3'h5, 7'h2A);
        chk("view", v2, view_q);
        chk("src", 1'b1, src_store_q);
        pm.press(CMD_APPLY, 3'h6, 7'h01);
        // this close lands while busy and must be lost
        pm.press(CMD_CLOSE, 3'h0, 7'h00);
        idle();
        chk("relays", v2, relays_q);
        chk("applied", 7'h05, applied_idx_q);
        chk("view", v2, view_q);
        chk("edited", 1'b0, display_edited_q);
        pm.press(CMD_SEL_STORE, 3'h7, 7'h47);
        chk("view", v1, view_q);
        chk("store_idx", 7'h01, store_idx_q);
        pm.press(CMD_TOGGLE_MB, 3'h0, 7'h12);
        chk("mb", 8'h01, mb_rows_q);
        pm.press(CMD_TOGGLE_BM, 3'h0, 7'h5A);
        chk("mb", 8'h00, mb_rows_q);
        chk("bm", 8'h01, bm_rows_q);
        pm.press(CMD_TOGGLE_MB, 3'h0, 7'h03);
        pm.press(CMD_TOGGLE_BM, 3'h7, 7'h40);
        chk("bm", 8'h80, bm_rows_q);
        pm.press(CMD_APPLY, 3'h3, 7'h46);
        idle();
        chk("relays", v1, relays_q);
        chk("applied", 7'h01, applied_idx_q);
        pm.key(4'h5);
        pm.press(CMD_SEL_STORE, 3'h2, 7'h10);
        pm.press(CMD_APPLY, 3'h1, 7'h22);
        idle();
        // neither source alone nor enable alone may fire
        pm.arm(1'b0, 1'b1);
        pm.trig();
        pm.arm(1'b1, 1'b0);
        pm.trig();
        idle();
        chk("relays", v2, relays_q);
        pm.arm(1'b1, 1'b1);
        pm.trig();
        idle();
        chk("relays", v1, relays_q);
        chk("applied", 7'h01, applied_idx_q);
        pm.press(CMD_SEL_RELAYS, 3'h4, 7'h33);
        chk("src", 1'b0, src_store_q);
        chk("view", v1, view_q);
        conclude();
    end
endmodule
`default_nettype wire
